/* File: testbench/ecc_enc_model.sv */
module ecc_enc_model (
    // Clock
    input wire logic mclk_i,
    // Encoder and trigger pins
    output logic [3:0] enc_a_o,
    output logic [3:0] enc_b_o,
    output logic trig_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] phase_q [4];

    initial begin
        enc_a_o = 4'h0;
        enc_b_o = 4'h0;
        trig_o = 1'b0;
        foreach (phase_q[i]) phase_q[i] = 2'h0;
    end

    // Gray order 00,10,11,01 counts up; 4 cycles a level beats the 3-stage filter
    task automatic step(input int ch, input bit up, input int n);
        repeat (n) begin
            @(posedge mclk_i);
            phase_q[ch] = up ? phase_q[ch] + 2'h1 : phase_q[ch] - 2'h1;
            enc_a_o[ch] <= phase_q[ch] inside {2'h1, 2'h2};
            enc_b_o[ch] <= phase_q[ch][1];
            repeat (3) @(posedge mclk_i);
        end
        // Let the filter and counter settle before software looks
        repeat (8) @(posedge mclk_i);
    endtask

    task automatic pulse();
        @(posedge mclk_i);
        trig_o <= 1'b1;
        repeat (4) @(posedge mclk_i);
        trig_o <= 1'b0;
        repeat (8) @(posedge mclk_i);
    endtask
endmodule

/* File: testbench/tb_ecc_top.sv */
module tb_ecc_top
    import ecc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk_i = 1'b0;
    logic reset_i, psel_i, penable_i, pwrite_i;
    logic [7:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o;
    logic pready_o, pslverr_o, trig_i;
    logic [3:0] enc_a_i, enc_b_i;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;

    always #5 mclk_i = ~mclk_i;

    ecc_top dut (.mclk_i(mclk_i), .reset_i(reset_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .enc_a_i(enc_a_i), .enc_b_i(enc_b_i), .trig_i(trig_i));
    ecc_enc_model enc (.mclk_i(mclk_i), .enc_a_o(enc_a_i), .enc_b_o(enc_b_i), .trig_o(trig_i));

    task automatic end_sim();
        $display("compares=%0d num_errors=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            $display("MISMATCH at %0t: run timed out", $time);
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic done(input string name);
        $display("test %s ended, errors so far %0d", name, num_errors);
    endtask

    // Idle cycle before each setup so no signal is driven twice in one step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge mclk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        do @(posedge mclk_i); while (pready_o !== 1'b1);
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        chk({31'h0, e}, 32'h0, "write error flag");
    endtask

    task automatic rd_exp(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x, "read data");
        chk({31'h0, e}, 32'h0, "read error flag");
    endtask

    task automatic bad(input logic w, input logic [7:0] a);
        logic [31:0] r;
        logic e;
        apb(w, a, 32'h0000ffff, r, e);
        chk({31'h0, e}, 32'h1, "error flag");
        chk(r, 32'h0, "error read data");
    endtask

    function automatic logic [7:0] ra(input int ch, input logic [3:0] off);
        return {2'b00, 2'(ch), off};
    endfunction

    // Preset is borrowed for the transfer and put back afterwards
    task automatic load_count(input int ch, input logic [23:0] v);
        logic [31:0] saved;
        logic e;
        apb(1'b0, ra(ch, CH_PRESET), 32'h0, saved, e);
        wr(ra(ch, CH_PRESET), {8'h00, v});
        wr(OFF_CMD, 32'h1 << (CMD_LOAD_LSB + ch));
        wr(ra(ch, CH_PRESET), saved);
    endtask

    initial begin
        logic [31:0] r;
        logic e;
        reset_i = 1'b1;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = 8'h00;
        pwdata_i = 32'h0;
        repeat (3) @(posedge mclk_i);
        reset_i <= 1'b0;
        for (int ch = 0; ch < 4; ch++) begin
            rd_exp(ra(ch, CH_CTRL), CTRL_RST);
            rd_exp(ra(ch, CH_PRESET), {8'h00, PRESET_RST});
            rd_exp(ra(ch, CH_COUNT), 32'h0);
        end
        rd_exp(OFF_STATUS, 32'h0000000f);
        done("defaults");
        for (int ch = 0; ch < 4; ch++) begin
            wr(ra(ch, CH_CTRL), 32'h000f4000 | 32'(ch));
        end
        for (int ch = 0; ch < 4; ch++) begin
            rd_exp(ra(ch, CH_CTRL), 32'h000f4000 | 32'(ch));
        end
        for (int m = 0; m < 4; m++) begin
            wr(ra(2, CH_MODE), 32'(m));
            rd_exp(ra(2, CH_CTRL), 32'h000f4000 | 32'(m));
            rd_exp(ra(2, CH_MODE), 32'(m));
        end
        done("control");
        wr(ra(0, CH_CTRL), 32'h00070000);
        load_count(0, 24'habcdef);
        rd_exp(ra(0, CH_COUNT), 32'h00abcdef);
        rd_exp(ra(0, CH_PRESET), {8'h00, PRESET_RST});
        enc.step(0, 1'b1, 3);
        rd_exp(ra(0, CH_COUNT), 32'h00abcdf2);
        wr(ra(0, CH_CTRL), 32'h00060000);
        rd_exp(OFF_STATUS, 32'h0000000e);
        enc.step(0, 1'b1, 2);
        rd_exp(ra(0, CH_COUNT), 32'h00abcdf2);
        wr(ra(0, CH_CTRL), 32'h00030000);
        enc.step(0, 1'b1, 2);
        rd_exp(ra(0, CH_COUNT), 32'h00abcdf2);
        wr(ra(0, CH_CTRL), 32'h00070000);
        enc.step(0, 1'b0, 1);
        rd_exp(ra(0, CH_COUNT), 32'h00abcdf1);
        load_count(0, 24'hffffff);
        enc.step(0, 1'b1, 1);
        rd_exp(ra(0, CH_COUNT), 32'h0);
        enc.step(0, 1'b0, 1);
        rd_exp(ra(0, CH_COUNT), 32'h00ffffff);
        wr(OFF_CMD, 32'h1 << CMD_CLR_LSB);
        rd_exp(ra(0, CH_COUNT), 32'h0);
        done("count");
        wr(ra(1, CH_PRESET), 32'h5);
        wr(ra(1, CH_CTRL), 32'h00070001);
        wr(OFF_CMD, 32'h1 << (CMD_CLR_LSB + 1));
        enc.step(1, 1'b1, 7);
        rd_exp(ra(1, CH_COUNT), 32'h5);
        enc.step(1, 1'b0, 7);
        rd_exp(ra(1, CH_COUNT), 32'h0);
        wr(ra(1, CH_MODE), 32'h3);
        enc.step(1, 1'b1, 6);
        rd_exp(ra(1, CH_COUNT), 32'h0);
        enc.step(1, 1'b0, 1);
        rd_exp(ra(1, CH_COUNT), 32'h5);
        wr(ra(1, CH_MODE), 32'h2);
        wr(OFF_CMD, 32'h1 << (CMD_CLR_LSB + 1));
        enc.step(1, 1'b1, 7);
        rd_exp(ra(1, CH_COUNT), 32'h5);
        apb(1'b0, OFF_STATUS, 32'h0, r, e);
        chk({31'h0, r[5]}, 32'h1, "halted flag");
        wr(OFF_CMD, 32'h1 << (CMD_CLR_LSB + 1));
        apb(1'b0, OFF_STATUS, 32'h0, r, e);
        chk({31'h0, r[5]}, 32'h0, "halted flag");
        enc.step(1, 1'b1, 1);
        rd_exp(ra(1, CH_COUNT), 32'h1);
        done("modes");
        wr(ra(2, CH_CTRL), 32'h00070000);
        wr(ra(3, CH_CTRL), 32'h00050000);
        load_count(2, 24'h000123);
        load_count(3, 24'h000456);
        enc.pulse();
        rd_exp(OFF_LATCH + 8'h08, 32'h123);
        rd_exp(OFF_LATCH + 8'h0c, 32'h0);
        load_count(2, 24'h000200);
        wr(OFF_CMD, 32'h3 << (CMD_TRIG_LSB + 2));
        rd_exp(OFF_LATCH + 8'h08, 32'h200);
        rd_exp(OFF_LATCH + 8'h0c, 32'h0);
        done("capture");
        wr(OFF_CMD, 32'h1 << CMD_FACTORY_BIT);
        rd_exp(ra(3, CH_CTRL), CTRL_RST);
        rd_exp(ra(1, CH_PRESET), {8'h00, PRESET_RST});
        bad(1'b0, 8'h70);
        bad(1'b1, 8'h01);
        wr(ra(0, CH_COUNT), 32'h55);
        rd_exp(ra(0, CH_COUNT), 32'h0);
        done("factory and errors");
        end_sim();
    end
endmodule

/* File: verilog/ecc_channel.sv */
module ecc_channel
    import ecc_pkg::*;
#(
    parameter int unsigned W = CNT_W
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // Encoder pins
    input wire logic enc_a_i,
    input wire logic enc_b_i,
    // Controls from the register file
    input wire logic enable_i,
    input wire logic capture_i,
    input wire ecc_mode_t mode_i,
    input wire logic [W-1:0] preset_i,
    input wire logic load_i,
    input wire logic clear_i,
    input wire logic trig_i,
    // State
    output logic [W-1:0] count_o,
    output logic [W-1:0] latch_o,
    output logic halted_o
);

    typedef struct packed {
        logic [2:0] a_s;
        logic [2:0] b_s;
        logic a_f;
        logic b_f;
        logic [W-1:0] count;
        logic [W-1:0] latch;
        logic halted;
    } ecc_ch_state_t;

    ecc_ch_state_t q;
    ecc_ch_state_t d;
    logic step;
    logic up_dir;

    always_comb begin
        d = q;
        d.a_s = {q.a_s[1:0], enc_a_i};
        d.b_s = {q.b_s[1:0], enc_b_i};
        // Only a level seen by the second and third stage is accepted
        if (q.a_s[1] == q.a_s[2]) begin
            d.a_f = q.a_s[2];
        end
        if (q.b_s[1] == q.b_s[2]) begin
            d.b_f = q.b_s[2];
        end
        // Both edges changing at once is a lost state: ignored
        step = (d.a_f ^ q.a_f) ^ (d.b_f ^ q.b_f);
        up_dir = d.a_f ^ q.b_f;
        if (clear_i) begin
            d.count = '0;
            d.halted = 1'b0;
        end else if (load_i) begin
            d.count = preset_i;
            d.halted = 1'b0;
        end else if (step && enable_i && !q.halted) begin
            unique case (mode_i)
                MODE_PLAIN: begin
                    d.count = up_dir ? q.count + 1'b1 : q.count - 1'b1;
                end
                MODE_RANGE: begin
                    if (up_dir && q.count < preset_i) begin
                        d.count = q.count + 1'b1;
                    end else if (!up_dir && q.count != '0) begin
                        d.count = q.count - 1'b1;
                    end
                end
                MODE_NORECYCLE: begin
                    // Stays stopped until software loads or clears
                    if (up_dir) begin
                        if (q.count == preset_i) begin
                            d.halted = 1'b1;
                        end else begin
                            d.count = q.count + 1'b1;
                        end
                    end else if (q.count == '0) begin
                        d.halted = 1'b1;
                    end else begin
                        d.count = q.count - 1'b1;
                    end
                end
                MODE_MODN: begin
                    if (up_dir) begin
                        d.count = (q.count == preset_i) ? '0 : q.count + 1'b1;
                    end else begin
                        d.count = (q.count == '0) ? preset_i : q.count - 1'b1;
                    end
                end
            endcase
        end
        if (trig_i && capture_i) begin
            d.latch = q.count;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign count_o = q.count;
    assign latch_o = q.latch;
    assign halted_o = q.halted;

    property p_load;
        @(posedge mclk_i) disable iff (reset_i)
        load_i && !clear_i |=> count_o == $past(preset_i);
    endproperty
    a_load: assert property (p_load) else $error("count not loaded from preset");

    property p_clear;
        @(posedge mclk_i) disable iff (reset_i)
        clear_i |=> count_o == '0 && !halted_o;
    endproperty
    a_clear: assert property (p_clear) else $error("count not cleared");

    property p_hold;
        @(posedge mclk_i) disable iff (reset_i)
        !enable_i && !load_i && !clear_i |=> $stable(count_o);
    endproperty
    a_hold: assert property (p_hold) else $error("disabled channel counted");

    property p_capture;
        @(posedge mclk_i) disable iff (reset_i)
        trig_i && capture_i |=> latch_o == $past(count_o);
    endproperty
    a_capture: assert property (p_capture) else $error("trigger did not capture");

    property p_nocapture;
        @(posedge mclk_i) disable iff (reset_i)
        !(trig_i && capture_i) |=> $stable(latch_o);
    endproperty
    a_nocapture: assert property (p_nocapture) else $error("latch changed");

    property p_plain;
        @(posedge mclk_i) disable iff (reset_i)
        step && up_dir && enable_i && !halted_o && !load_i && !clear_i
            && mode_i == MODE_PLAIN |=> count_o == W'($past(count_o) + 1'b1);
    endproperty
    a_plain: assert property (p_plain) else $error("plain count wrong");

    property p_range;
        @(posedge mclk_i) disable iff (reset_i)
        step && up_dir && enable_i && !load_i && !clear_i && mode_i == MODE_RANGE
            && count_o == preset_i |=> $stable(count_o);
    endproperty
    a_range: assert property (p_range) else $error("range limit passed");

    property p_modn;
        @(posedge mclk_i) disable iff (reset_i)
        step && up_dir && enable_i && !halted_o && !load_i && !clear_i
            && mode_i == MODE_MODN && count_o == preset_i |=> count_o == '0;
    endproperty
    a_modn: assert property (p_modn) else $error("modulo wrap wrong");

endmodule

/* File: verilog/ecc_pkg.sv */
package ecc_pkg;

    // Channel count and counter width
    localparam int unsigned NUM_CH = 4;
    localparam int unsigned CNT_W = 24;

    // Per-channel register block: channel number in paddr[5:4]
    localparam logic [3:0] CH_CTRL = 4'h0;
    localparam logic [3:0] CH_MODE = 4'h4;
    localparam logic [3:0] CH_PRESET = 4'h8;
    localparam logic [3:0] CH_COUNT = 4'hc;

    // Shared registers
    localparam logic [7:0] OFF_CMD = 8'h40;
    localparam logic [7:0] OFF_LATCH = 8'h50;
    localparam logic [7:0] OFF_STATUS = 8'h60;

    // Control register fields
    localparam int unsigned MODE_LSB = 0;
    localparam int unsigned MODE_W = 2;
    localparam int unsigned CNT_EN_BIT = 16;
    localparam int unsigned CAPT_BIT = 17;
    localparam int unsigned MASTER_BIT = 18;
    localparam logic [31:0] MODE_MASK = 32'h00000003;

    // Command register fields, one bit per channel in each group
    localparam int unsigned CMD_LOAD_LSB = 0;
    localparam int unsigned CMD_CLR_LSB = 4;
    localparam int unsigned CMD_TRIG_LSB = 8;
    localparam int unsigned CMD_FACTORY_BIT = 12;

    // Reset and factory values
    localparam logic [31:0] CTRL_RST = 32'h00874000;
    localparam logic [23:0] PRESET_RST = 24'h0001f3;

    typedef enum logic [1:0] {
        MODE_PLAIN = 2'h0,
        MODE_RANGE = 2'h1,
        MODE_NORECYCLE = 2'h2,
        MODE_MODN = 2'h3
    } ecc_mode_t;

endpackage

/* File: verilog/ecc_top.sv */
// Contract
// - Four channels 0-3, each with a control register replaced whole by a write.
// - Counters are unsigned 24-bit; a load forces the count to the preset, unless a reset-count comes in the same command write.
// - Each channel can be enabled or disabled on its own.
// - A 2-bit mode field can be written leaving other control bits unchanged.
// - Mode 0 plain, 1 range-limit, 2 non-recycle, 3 modulo-N.
// - A reset-count command sets the channel count to zero.
// - With capture on a trigger copies count to latch; otherwise latch holds.
// - A channel counts only while its master enable is set.
// - Factory defaults: control 0x00874000, preset 0x000001F3 per channel.
module ecc_top
    import ecc_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Encoder and trigger pins
    input wire logic [NUM_CH-1:0] enc_a_i,
    input wire logic [NUM_CH-1:0] enc_b_i,
    input wire logic trig_i
);

    typedef struct packed {
        logic [NUM_CH-1:0][31:0] ctrl;
        logic [NUM_CH-1:0][CNT_W-1:0] preset;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [2:0] trig_s;
        logic trig_f;
    } ecc_top_state_t;

    ecc_top_state_t q;
    ecc_top_state_t d;

    // Channel side
    logic [NUM_CH-1:0][CNT_W-1:0] count;
    logic [NUM_CH-1:0][CNT_W-1:0] latch;
    logic [NUM_CH-1:0] halted;
    logic [NUM_CH-1:0] enable;
    logic [NUM_CH-1:0] load_p;
    logic [NUM_CH-1:0] clear_p;
    logic [NUM_CH-1:0] trig_p;

    // Bus decode
    logic setup;
    logic wr;
    logic in_ch;
    logic [1:0] ch_sel;
    logic [31:0] ctrl_sel;
    logic wr_ctrl;
    logic wr_mode;
    logic wr_preset;
    logic wr_cmd;
    logic wr_factory;
    logic pin_trig;
    logic [31:0] rd_data;
    logic rd_err;

    always_comb begin
        d = q;
        setup = psel_i && !penable_i;
        // Writes land only at the completing edge of the access phase
        wr = psel_i && penable_i && pwrite_i && q.pready;
        in_ch = (paddr_i[7:6] == 2'h0);
        ch_sel = paddr_i[5:4];
        ctrl_sel = q.ctrl[ch_sel];
        wr_ctrl = wr && in_ch && paddr_i[3:0] == CH_CTRL;
        wr_mode = wr && in_ch && paddr_i[3:0] == CH_MODE;
        wr_preset = wr && in_ch && paddr_i[3:0] == CH_PRESET;
        wr_cmd = wr && paddr_i == OFF_CMD;
        wr_factory = wr_cmd && pwdata_i[CMD_FACTORY_BIT];

        // Read decode; misaligned or unknown addresses give an error
        rd_data = 32'h00000000;
        rd_err = 1'b0;
        if (paddr_i[1:0] != 2'h0) begin
            rd_err = 1'b1;
        end else if (in_ch) begin
            unique case (paddr_i[3:0])
                CH_CTRL: rd_data = ctrl_sel;
                CH_MODE: rd_data = ctrl_sel & MODE_MASK;
                CH_PRESET: rd_data = {8'h00, q.preset[ch_sel]};
                CH_COUNT: rd_data = {8'h00, count[ch_sel]};
                default: rd_err = 1'b1;
            endcase
        end else if (paddr_i == OFF_CMD) begin
            // Command bits are pulses: nothing to read back
            rd_data = 32'h00000000;
        end else if (paddr_i[7:4] == OFF_LATCH[7:4]) begin
            rd_data = {8'h00, latch[paddr_i[3:2]]};
        end else if (paddr_i == OFF_STATUS) begin
            rd_data = {24'h000000, halted, enable};
        end else begin
            rd_err = 1'b1;
        end

        // Zero-wait answer: prepared in setup, shown during access
        d.pready = setup;
        d.pslverr = setup && rd_err;
        d.prdata = (setup && !pwrite_i) ? rd_data : 32'h00000000;

        if (wr_ctrl) begin
            d.ctrl[ch_sel] = pwdata_i;
        end
        if (wr_mode) begin
            d.ctrl[ch_sel] = (ctrl_sel & ~MODE_MASK) | (pwdata_i & MODE_MASK);
        end
        if (wr_preset) begin
            d.preset[ch_sel] = pwdata_i[CNT_W-1:0];
        end
        if (wr_factory) begin
            d.ctrl = {NUM_CH{CTRL_RST}};
            d.preset = {NUM_CH{PRESET_RST}};
        end

        // External trigger pin, three-stage filter, rising edge only
        d.trig_s = {q.trig_s[1:0], trig_i};
        if (q.trig_s[1] == q.trig_s[2]) begin
            d.trig_f = q.trig_s[2];
        end
        pin_trig = d.trig_f && !q.trig_f;

        // The load copies the live preset; software may restore it right after
        for (int c = 0; c < NUM_CH; c++) begin
            enable[c] = q.ctrl[c][MASTER_BIT] && q.ctrl[c][CNT_EN_BIT];
            load_p[c] = wr_cmd && pwdata_i[CMD_LOAD_LSB + c];
            clear_p[c] = wr_cmd && pwdata_i[CMD_CLR_LSB + c];
            trig_p[c] = pin_trig || (wr_cmd && pwdata_i[CMD_TRIG_LSB + c]);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            q <= '{ctrl: {NUM_CH{CTRL_RST}}, preset: {NUM_CH{PRESET_RST}}, default: '0};
        end else begin
            q <= d;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            ecc_channel #(
                .W(CNT_W)
            ) u_ch (
                .mclk_i(mclk_i),
                .reset_i(reset_i),
                .enc_a_i(enc_a_i[g]),
                .enc_b_i(enc_b_i[g]),
                .enable_i(enable[g]),
                .capture_i(q.ctrl[g][CAPT_BIT]),
                .mode_i(ecc_mode_t'(q.ctrl[g][MODE_LSB +: MODE_W])),
                .preset_i(q.preset[g]),
                .load_i(load_p[g]),
                .clear_i(clear_p[g]),
                .trig_i(trig_p[g]),
                .count_o(count[g]),
                .latch_o(latch[g]),
                .halted_o(halted[g])
            );
        end
    endgenerate

    assign prdata_o = q.prdata;
    assign pready_o = q.pready;
    assign pslverr_o = q.pslverr;

    property p_ctrl_write;
        @(posedge mclk_i) disable iff (reset_i)
        wr_ctrl |=> q.ctrl[$past(ch_sel)] == $past(pwdata_i);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control not replaced");

    property p_mode_write;
        @(posedge mclk_i) disable iff (reset_i)
        wr_mode |=> (q.ctrl[$past(ch_sel)] & ~MODE_MASK) == ($past(ctrl_sel) & ~MODE_MASK)
            && (q.ctrl[$past(ch_sel)] & MODE_MASK) == ($past(pwdata_i) & MODE_MASK);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode write disturbed bits");

    property p_factory;
        @(posedge mclk_i) disable iff (reset_i)
        wr_factory |=> q.ctrl == {NUM_CH{CTRL_RST}} && q.preset == {NUM_CH{PRESET_RST}};
    endproperty
    a_factory: assert property (p_factory) else $error("factory values not loaded");

    property p_enable;
        @(posedge mclk_i) disable iff (reset_i)
        wr_ctrl && !pwdata_i[MASTER_BIT] |=> !enable[$past(ch_sel)];
    endproperty
    a_enable: assert property (p_enable) else $error("channel enabled without master");

    property p_answer;
        @(posedge mclk_i) disable iff (reset_i)
        setup |=> pready_o ##1 !pready_o;
    endproperty
    a_answer: assert property (p_answer) else $error("bus answer timing wrong");

    property p_err_answer;
        @(posedge mclk_i) disable iff (reset_i)
        setup && paddr_i[1:0] != 2'h0 |=> pready_o && pslverr_o;
    endproperty
    a_err_answer: assert property (p_err_answer) else $error("misaligned access not refused");

    property p_err_no_write;
        @(posedge mclk_i) disable iff (reset_i)
        pslverr_o |=> $stable(q.ctrl) && $stable(q.preset);
    endproperty
    a_err_no_write: assert property (p_err_no_write) else $error("refused write changed state");

    property p_rdata_idle;
        @(posedge mclk_i) disable iff (reset_i)
        !pready_o |-> prdata_o == 32'h00000000 && !pslverr_o;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("bus outputs not idle");

    property p_ctrl_hold;
        @(posedge mclk_i) disable iff (reset_i)
        !wr_ctrl && !wr_mode && !wr_factory |=> $stable(q.ctrl);
    endproperty
    a_ctrl_hold: assert property (p_ctrl_hold) else $error("control changed unwritten");

    property p_preset_write;
        @(posedge mclk_i) disable iff (reset_i)
        wr_preset |=> q.preset[$past(ch_sel)] == $past(pwdata_i[CNT_W-1:0]);
    endproperty
    a_preset_write: assert property (p_preset_write) else $error("preset not written");

    property p_preset_hold;
        @(posedge mclk_i) disable iff (reset_i)
        !wr_preset && !wr_factory |=> $stable(q.preset);
    endproperty
    a_preset_hold: assert property (p_preset_hold) else $error("preset changed unwritten");

    property p_status_read;
        @(posedge mclk_i) disable iff (reset_i)
        setup && !pwrite_i && paddr_i == OFF_STATUS
            |=> prdata_o == {24'h000000, $past(halted), $past(enable)};
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong");

    property p_count_read;
        @(posedge mclk_i) disable iff (reset_i)
        setup && !pwrite_i && in_ch && paddr_i[3:0] == CH_COUNT
            |=> prdata_o == {8'h00, $past(count[ch_sel])};
    endproperty
    a_count_read: assert property (p_count_read) else $error("count read wrong");

    property p_enable_on;
        @(posedge mclk_i) disable iff (reset_i)
        wr_ctrl && pwdata_i[MASTER_BIT] && pwdata_i[CNT_EN_BIT] |=> enable[$past(ch_sel)];
    endproperty
    a_enable_on: assert property (p_enable_on) else $error("channel not enabled");

    property p_cnt_en_off;
        @(posedge mclk_i) disable iff (reset_i)
        wr_ctrl && !pwdata_i[CNT_EN_BIT] |=> !enable[$past(ch_sel)];
    endproperty
    a_cnt_en_off: assert property (p_cnt_en_off) else $error("channel not disabled");

    property p_mode_read;
        @(posedge mclk_i) disable iff (reset_i)
        setup && !pwrite_i && in_ch && paddr_i[3:0] == CH_MODE
            |=> prdata_o == ($past(ctrl_sel) & MODE_MASK);
    endproperty
    a_mode_read: assert property (p_mode_read) else $error("mode read wrong");

    property p_pin_all;
        @(posedge mclk_i) disable iff (reset_i)
        pin_trig |-> &trig_p;
    endproperty
    a_pin_all: assert property (p_pin_all) else $error("pin trigger missed a channel");

    property p_trig_pulse;
        @(posedge mclk_i) disable iff (reset_i)
        pin_trig |=> !pin_trig;
    endproperty
    a_trig_pulse: assert property (p_trig_pulse) else $error("pin trigger not one pulse");

    property p_clear_cmd;
        @(posedge mclk_i) disable iff (reset_i)
        wr_cmd && pwdata_i[CMD_CLR_LSB] |=> count[0] == '0;
    endproperty
    a_clear_cmd: assert property (p_clear_cmd) else $error("clear command missed");

    property p_latch_read;
        @(posedge mclk_i) disable iff (reset_i)
        setup && !pwrite_i && paddr_i[7:4] == OFF_LATCH[7:4] && paddr_i[1:0] == 2'h0
            |=> prdata_o == {8'h00, $past(latch[paddr_i[3:2]])};
    endproperty
    a_latch_read: assert property (p_latch_read) else $error("latch read wrong");

    property p_cmd_read;
        @(posedge mclk_i) disable iff (reset_i)
        setup && !pwrite_i && paddr_i == OFF_CMD |=> prdata_o == 32'h00000000 && !pslverr_o;
    endproperty
    a_cmd_read: assert property (p_cmd_read) else $error("command read not zero");

endmodule
